// ==== include/irq_route_pkg.sv ====
/*
 * constants and carrier types for the dual interrupt routing block.
 * assumes a single core clock domain and static board settings.
 */
// What this block does
// - independent mode keeps both controllers unlinked, eight levels each.
// - independent: first takes control lines, second onboard sources only.
// - independent mode drives two separate bus request lines.
// - independent: response port read goes to the addressed controller.
// - cascaded mode drives at most one bus request line.
// - no external sorter: cascaded pair drives the pINT line directly.
// - with sorter: vectored lines, one cascaded, two independent.
// - selectable vectored line for cascade, and one per controller.
// - acknowledge response on: response byte driven during sINTA read.
// - acknowledge response off: ignore sINTA, answer only port reads.
// - cascaded: one sixteen-level system, either controller on top.
// - polarity-adjusted control lines feed first controller, 0 highest.
// - onboard sources into the priority matrix are active low.
package irq_route_pkg;

    localparam int NUM_CTL = 8;
    localparam int NUM_LVL = 8;
    localparam int NUM_VI = 8;
    localparam int NUM_SRC = 10;
    localparam int SEL_W = 4;
    localparam int LINE_W = 3;
    localparam int IDX16_W = 4;
    localparam int BASE8_LSB = 3;
    localparam int BASE16_LSB = 4;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    typedef struct packed {
        logic cascaded;
        logic a_higher;
        logic use_vectored;
        logic [LINE_W-1:0] cas_line;
        logic [LINE_W-1:0] line_a;
        logic [LINE_W-1:0] line_b;
        logic ack_resp;
        logic steer_indep;
    } cfg_t;

    typedef struct packed {
        cfg_t cfg;
        logic cfg_valid;
        logic pint_oe;
        logic [NUM_VI-1:0] vi_oe;
        logic [7:0] dout;
        logic dout_oe;
    } state_t;

endpackage

// ==== verilog/dual_interrupt_routing_response.sv ====
/*
 * routing and response logic around two eight-input priority controllers.
 * assumes static settings, synchronous inputs, decoded read strobes and
 * a board wire that is pulled low wherever an output enable is high.
 */
`timescale 1ns/1ps
module dual_interrupt_routing_response #(
    parameter int NUM_SRC = irq_route_pkg::NUM_SRC
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic cascade_independent_setting_i,
    input wire logic ctl_a_higher_i,
    input wire logic bus_line_select_setting_i,
    input wire logic [2:0] cascade_line_i,
    input wire logic [2:0] line_a_i,
    input wire logic [2:0] line_b_i,
    input wire logic acknowledge_response_setting_i,
    input wire logic response_read_steering_setting_i,
    input wire logic [7:0] control_line_i,
    input wire logic [7:0] control_line_polarity_setting_i,
    input wire logic [NUM_SRC-1:0] onboard_src_n_i,
    input wire logic [31:0] onboard_source_priority_matrix_i,
    input wire logic [7:0] mask_a_i,
    input wire logic [7:0] mask_b_i,
    input wire logic enable_a_i,
    input wire logic enable_b_i,
    input wire logic [7:0] vec_base_a_i,
    input wire logic [7:0] vec_base_b_i,
    input wire logic sinta_i,
    input wire logic pdbin_i,
    input wire logic rd_resp_a_i,
    input wire logic rd_resp_b_i,
    output logic pint_oe_o,
    output logic [7:0] vi_oe_o,
    output logic [7:0] data_in_o,
    output logic data_in_oe_o
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_sync_ff;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // priority decode
    // ------------------------------------------------------------
    function automatic logic [3:0] prio8(input logic [7:0] req);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (req[i]) begin
                r = {1'b1, i[2:0]};
            end
        end
        return r;
    endfunction

    logic [7:0] req_a;
    logic [7:0] req_b;
    logic [7:0] pend_a;
    logic [7:0] pend_b;

    // polarity adjusted lines, line 0 on input 0
    assign req_a = control_line_i ^ control_line_polarity_setting_i;

    genvar g;
    generate
        for (g = 0; g < irq_route_pkg::NUM_LVL; g++) begin : g_matrix
            logic [irq_route_pkg::SEL_W-1:0] sel;
            assign sel = onboard_source_priority_matrix_i[g*4 +: 4];
            // unused or out of range selections never request
            assign req_b[g] = (int'(sel) < NUM_SRC) ?
                              ~onboard_src_n_i[sel] : 1'b0;
        end
    endgenerate

    assign pend_a = req_a & mask_a_i & {8{enable_a_i}};
    assign pend_b = req_b & mask_b_i & {8{enable_b_i}};

    logic [3:0] pa;
    logic [3:0] pb;
    logic [7:0] resp_a;
    logic [7:0] resp_b;
    logic [7:0] resp_c;
    logic any_a;
    logic any_b;
    logic [3:0] idx_c;
    irq_route_pkg::state_t state_ff;
    irq_route_pkg::state_t nxt_state;

    assign pa = prio8(pend_a);
    assign pb = prio8(pend_b);
    assign any_a = pa[3];
    assign any_b = pb[3];
    assign resp_a = {vec_base_a_i[7:3], pa[2:0]};
    assign resp_b = {vec_base_b_i[7:3], pb[2:0]};

    // ------------------------------------------------------------
    // cascaded sixteen levels
    // ------------------------------------------------------------
    always_comb begin
        idx_c = 4'h0;
        if (state_ff.cfg.a_higher) begin
            idx_c = any_a ? {1'b0, pa[2:0]} : {1'b1, pb[2:0]};
        end else begin
            idx_c = any_b ? {1'b0, pb[2:0]} : {1'b1, pa[2:0]};
        end
    end
    assign resp_c = {vec_base_a_i[7:4], idx_c};

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic ack_hit;
    logic port_hit;

    assign ack_hit = sinta_i & pdbin_i & state_ff.cfg.ack_resp;
    assign port_hit = pdbin_i & (rd_resp_a_i | rd_resp_b_i);

    always_comb begin
        nxt_state = state_ff;
        if (!state_ff.cfg_valid) begin
            // settings taken once, then held
            nxt_state.cfg.cascaded = cascade_independent_setting_i;
            nxt_state.cfg.a_higher = ctl_a_higher_i;
            nxt_state.cfg.use_vectored = bus_line_select_setting_i;
            nxt_state.cfg.cas_line = cascade_line_i;
            nxt_state.cfg.line_a = line_a_i;
            nxt_state.cfg.line_b = line_b_i;
            nxt_state.cfg.ack_resp = acknowledge_response_setting_i;
            nxt_state.cfg.steer_indep = response_read_steering_setting_i;
            nxt_state.cfg_valid = 1'b1;
        end else begin
            nxt_state.pint_oe = 1'b0;
            nxt_state.vi_oe = '0;
            if (state_ff.cfg.cascaded) begin
                if (state_ff.cfg.use_vectored) begin
                    nxt_state.vi_oe[state_ff.cfg.cas_line] =
                        any_a | any_b;
                end else begin
                    nxt_state.pint_oe = any_a | any_b;
                end
            end else begin
                // two lines even without a sorter setting
                nxt_state.vi_oe[state_ff.cfg.line_a] = any_a;
                nxt_state.vi_oe[state_ff.cfg.line_b] =
                    nxt_state.vi_oe[state_ff.cfg.line_b] | any_b;
            end
            nxt_state.dout_oe = ack_hit | port_hit;
            nxt_state.dout = irq_route_pkg::RESET_BYTE;
            if (state_ff.cfg.cascaded || !state_ff.cfg.steer_indep) begin
                nxt_state.dout = resp_c;
                if (!state_ff.cfg.cascaded) begin
                    nxt_state.dout = any_a ? resp_a : resp_b;
                end
            end else if (port_hit) begin
                nxt_state.dout = rd_resp_b_i ? resp_b : resp_a;
            end else begin
                nxt_state.dout = any_a ? resp_a : resp_b;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            state_ff <= '0;
        end else if (ce_i) begin
            state_ff <= nxt_state;
        end
    end

    assign pint_oe_o = state_ff.pint_oe;
    assign vi_oe_o = state_ff.vi_oe;
    assign data_in_o = state_ff.dout;
    assign data_in_oe_o = state_ff.dout_oe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_sync_ff);

    logic live_ff;
    logic live;

    // previous edge updated state with settings already held
    always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            live_ff <= 1'b0;
        end else begin
            live_ff <= ce_i & state_ff.cfg_valid;
        end
    end
    assign live = state_ff.cfg_valid & ce_i & live_ff;

    a_indep_two_lines: assert property (
        live && !state_ff.cfg.cascaded && $past(any_a) && $past(any_b)
        && state_ff.cfg.line_a != state_ff.cfg.line_b
        |-> $countones(vi_oe_o) == 2 && !pint_oe_o)
        else $error("independent mode did not drive two lines");
    a_cascade_one_line: assert property (
        live && state_ff.cfg.cascaded
        |-> $countones({vi_oe_o, pint_oe_o}) <= 1)
        else $error("cascaded mode drove more than one line");
    a_pint_direct: assert property (
        live && state_ff.cfg.cascaded && !state_ff.cfg.use_vectored
        |-> pint_oe_o == $past(any_a | any_b) && vi_oe_o == 8'h00)
        else $error("pINT not following pending requests");
    a_vector_select: assert property (
        live && state_ff.cfg.cascaded && state_ff.cfg.use_vectored
        |-> vi_oe_o[state_ff.cfg.cas_line] == $past(any_a | any_b))
        else $error("selected vectored line wrong");
    a_ack_byte: assert property (
        ce_i && state_ff.cfg_valid && state_ff.cfg.ack_resp && sinta_i
        && pdbin_i ##1 ce_i |-> data_in_oe_o)
        else $error("no byte during acknowledge");
    a_ack_ignored: assert property (
        ce_i && state_ff.cfg_valid && !state_ff.cfg.ack_resp && sinta_i
        && !rd_resp_a_i && !rd_resp_b_i ##1 ce_i |-> !data_in_oe_o)
        else $error("acknowledge answered while disabled");
    a_read_steer: assert property (
        ce_i && state_ff.cfg_valid && !state_ff.cfg.cascaded
        && state_ff.cfg.steer_indep && pdbin_i && rd_resp_b_i
        ##1 ce_i |-> data_in_o == $past(resp_b))
        else $error("response read not steered");
    a_cfg_static: assert property (
        state_ff.cfg_valid |=> $stable(state_ff.cfg))
        else $error("settings changed during operation");
    a_line_release: assert property (
        live && !$past(any_a) && !$past(any_b)
        |-> !pint_oe_o && vi_oe_o == 8'h00)
        else $error("line driven without pending request");
    a_ctl_prio: assert property (
        pend_a[0] |-> pa == 4'h8)
        else $error("control line 0 not highest");

    c_cascade_pint: cover property (live && pint_oe_o);
    c_indep_both: cover property (live && $countones(vi_oe_o) == 2);
    c_ack_cycle: cover property (sinta_i && pdbin_i ##1 data_in_oe_o);
    c_port_read: cover property (rd_resp_b_i && pdbin_i ##1 data_in_oe_o);

endmodule

// ==== bench/cpu_bus_model.sv ====
/*
 * behavioural bus master for the routing block: acknowledge and port reads.
 * assumes the bench changes op_i just after a falling clock edge.
 */
`timescale 1ns/1ps
module cpu_bus_model #(
    parameter logic [7:0] EXT_VECTOR = 8'hc7 // arbitrary value
) (
    input wire logic [1:0] op_i,
    input wire logic [7:0] data_in_i,
    input wire logic data_in_oe_i,
    output logic sinta_o,
    output logic pdbin_o,
    output logic rd_a_o,
    output logic rd_b_o,
    output logic [7:0] bus_byte_o
);
    // ----------------------------------------
    // strobes, held for as long as op_i holds
    // ----------------------------------------
    assign sinta_o = (op_i == 2'h1);
    assign pdbin_o = (op_i != 2'h0);
    assign rd_a_o = (op_i == 2'h2);
    assign rd_b_o = (op_i == 2'h3);
    // external controller fills the bus when the board stays off it
    assign bus_byte_o = data_in_oe_i ? data_in_i : EXT_VECTOR;
endmodule

// ==== bench/tb_top.sv ====
/*
 * self-checking bench for the dual interrupt routing block.
 * assumes the design and its package are compiled first.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    $display("ERROR %s exp %h got %h", nm, e, g); n_fail++; end end
module tb_top;
    typedef struct {string nm; logic [17:0] v;} note_t;
    logic core_clk = 1'b0, rst_n = 1'b0, casc, vsel, ack, steer, ce, ahi;
    logic [2:0] cl, la, lb;
    logic [7:0] ctl, pol, ma, mb, ba, bb, dout, vi, bus_byte;
    logic [9:0] src_n;
    logic [31:0] mtx;
    logic ea, eb, sinta, pdbin, rda, rdb, pint, doe;
    logic [1:0] op;
    int n_fail = 0, checks_done = 0;
    integer seed = 32'hf5e20741;
    note_t q[$];
    note_t e;
    always #2 core_clk = ~core_clk;
    dual_interrupt_routing_response dual_interrupt_routing_response_i (
        .core_clk_i(core_clk), .rst_n_i(rst_n), .ce_i(ce),
        .cascade_independent_setting_i(casc), .ctl_a_higher_i(ahi),
        .bus_line_select_setting_i(vsel), .cascade_line_i(cl),
        .line_a_i(la), .line_b_i(lb),
        .acknowledge_response_setting_i(ack),
        .response_read_steering_setting_i(steer), .control_line_i(ctl),
        .control_line_polarity_setting_i(pol), .onboard_src_n_i(src_n),
        .onboard_source_priority_matrix_i(mtx), .mask_a_i(ma),
        .mask_b_i(mb), .enable_a_i(ea), .enable_b_i(eb),
        .vec_base_a_i(ba), .vec_base_b_i(bb), .sinta_i(sinta),
        .pdbin_i(pdbin), .rd_resp_a_i(rda), .rd_resp_b_i(rdb),
        .pint_oe_o(pint), .vi_oe_o(vi), .data_in_o(dout),
        .data_in_oe_o(doe));
    cpu_bus_model cpu_bus_model_i (.op_i(op), .data_in_i(dout),
        .data_in_oe_i(doe), .sinta_o(sinta), .pdbin_o(pdbin),
        .rd_a_o(rda), .rd_b_o(rdb), .bus_byte_o(bus_byte));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task complete_run();
        if (n_fail == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task setup(input logic c, input logic v, input logic a,
               input logic s);
        casc = c; vsel = v; ack = a; steer = s; rst_n = 1'b0;
        repeat (10) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (5) @(negedge core_clk);
    endtask
    // note the expected outputs once registered, then let the check land
    task expect_out(input string nm, input logic p, input logic [7:0] v,
                    input logic o, input logic [7:0] d);
        repeat (2) @(negedge core_clk);
        q.push_back('{nm, {p, v, o, d}});
        @(negedge core_clk);
    endtask
    // ----------------------------------------
    // monitor
    // ----------------------------------------
    always @(posedge core_clk) begin
        #1;
        if (q.size() > 0) begin
            e = q.pop_front();
            `CHK(e.nm, e.v, {pint, vi, doe, doe ? dout : 8'h00})
            `CHK("bus_byte", e.v[8] ? e.v[7:0] : cpu_bus_model_i.EXT_VECTOR, bus_byte)
        end
    end
    initial begin
        #(4 * 2000);
        n_fail++;
        complete_run();
    end
    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    initial begin
        op = 2'h0; ctl = 8'h00; pol = 8'h00; src_n = 10'h3ff;
        ce = 1'b1; ahi = 1'b1;
        mtx = 32'hffff_ffff; ma = 8'hff; mb = 8'hff; ea = 1'b1; eb = 1'b1;
        cl = 3'($random(seed)); la = 3'($random(seed)); lb = ~la;
        ba = 8'($random(seed)); bb = 8'($random(seed));
        setup(1'b1, 1'b0, 1'b1, 1'b0);
        ctl = 8'h01; vsel = 1'b1;
        expect_out("pint", 1'b1, 8'h00, 1'b0, 8'h00);
        ce = 1'b0; ctl = 8'h00;
        expect_out("frozen", 1'b1, 8'h00, 1'b0, 8'h00);
        ce = 1'b1;
        expect_out("pint_off", 1'b0, 8'h00, 1'b0, 8'h00);
        pol = 8'h08; mtx[3:0] = 4'h2; src_n[2] = 1'b0; op = 2'h1;
        ctl = 8'h30;
        expect_out("ack", 1'b1, 8'h00, 1'b1, {ba[7:4], 4'h3});
        ma = 8'hf7; ctl = 8'h00;
        expect_out("ack_b", 1'b1, 8'h00, 1'b1, {ba[7:4], 4'h8});
        op = 2'h0; pol = 8'h00; src_n = 10'h3ff; ma = 8'hff;
        expect_out("idle", 1'b0, 8'h00, 1'b0, 8'h00);
        ahi = 1'b0;
        setup(1'b1, 1'b1, 1'b0, 1'b0);
        ctl = 8'h80;
        expect_out("vec", 1'b0, 8'h01 << cl, 1'b0, 8'h00);
        op = 2'h1;
        expect_out("sinta_off", 1'b0, 8'h01 << cl, 1'b0, 8'h00);
        op = 2'h2;
        expect_out("rd_a", 1'b0, 8'h01 << cl, 1'b1, {ba[7:4], 4'hf});
        op = 2'h0; ctl = 8'h00;
        setup(1'b0, 1'b0, 1'b0, 1'b1);
        ctl = 8'h02;
        expect_out("ind_a", 1'b0, 8'h01 << la, 1'b0, 8'h00);
        mtx[23:20] = 4'h4; src_n[4] = 1'b0;
        expect_out("ind_ab", 1'b0, (8'h01 << la) | (8'h01 << lb),
                   1'b0, 8'h00);
        op = 2'h3;
        expect_out("rd_b", 1'b0, (8'h01 << la) | (8'h01 << lb),
                   1'b1, {bb[7:3], 3'h5});
        op = 2'h2;
        expect_out("rd_a2", 1'b0, (8'h01 << la) | (8'h01 << lb),
                   1'b1, {ba[7:3], 3'h1});
        op = 2'h0; eb = 1'b0;
        expect_out("b_off", 1'b0, 8'h01 << la, 1'b0, 8'h00);
        repeat (2) @(negedge core_clk);
        complete_run();
    end
endmodule
